// ===== rtl/fdio_pkg.sv
// Package for the feeder discrete I/O supervision block.
// Holds the register map, field positions, reset values, timing counts and carrier types.
// Assumes a 250 MHz core clock and a 32-bit APB register bus.
package fdio_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned QUAL_MIN_MS = 50;
  // A tick count of QUAL_MIN_MS + 2 guarantees strictly more than the minimum.
  localparam int unsigned QUAL_TICKS = QUAL_MIN_MS + 2;
  localparam int unsigned MS_W = 10;
  localparam logic [MS_W-1:0] MISS_MS_MIN = 10'd20;
  localparam logic [MS_W-1:0] MISS_MS_MAX = 10'd999;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MISS_MS = 8'h04;
  localparam logic [7:0] ADDR_FEED_MS = 8'h08;
  localparam logic [7:0] ADDR_BATCH = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_INT_STAT = 8'h14;
  localparam logic [7:0] ADDR_INT_MASK = 8'h18;
  localparam logic [7:0] ADDR_CMD = 8'h1c;

  localparam int unsigned CTRL_DOUBLE_EN = 0;
  localparam int unsigned CTRL_MISS_EN = 1;
  localparam int unsigned CTRL_HALT_EN = 2;
  localparam int unsigned CTRL_ACK_REQ = 3;
  localparam logic [3:0] CTRL_RESET = 4'h7;
  localparam logic [MS_W-1:0] MISS_MS_RESET = 10'd100;
  localparam logic [MS_W-1:0] FEED_MS_RESET = 10'd100;
  localparam logic [15:0] BATCH_RESET = 16'h0000;

  localparam int unsigned CMD_RESUME = 0;
  localparam int unsigned CMD_CLR_DONE = 1;

  localparam int unsigned EV_DOUBLE = 0;
  localparam int unsigned EV_MISS = 1;
  localparam int unsigned EV_DONE = 2;
  localparam int unsigned EV_LOW_STACK = 3;
  localparam int unsigned EV_HALT = 4;
  localparam int unsigned EV_N = 5;

  localparam int unsigned IN_DOUBLE = 0;
  localparam int unsigned IN_LOW_STACK = 1;
  localparam int unsigned IN_RUN_PERMIT = 2;
  localparam int unsigned IN_TRIGGER = 3;
  localparam int unsigned IN_N = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {FEED_IDLE, FEED_RUN, FEED_HALT, FEED_WAIT_ACK} fdio_feed_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } fdio_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } fdio_apb_rsp_s;

  typedef struct packed {
    logic doubleDet;
    logic lowStack;
    logic runPermit;
    logic triggerN;
  } fdio_pin_in_s;

  typedef struct packed {
    logic doubleMiss;
    logic busyDone;
    logic ready;
    logic lowStackRpt;
    logic motorRun;
  } fdio_pin_out_s;

endpackage

// ===== rtl/fdio_input_qual.sv
// Synchroniser and minimum pulse time qualifier for one discrete input.
// Assumes msTick is a one-cycle pulse once per millisecond on core_clk.
`timescale 1ns/100ps
module fdio_input_qual #(
  parameter int unsigned QUAL_TICKS = 52
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Time base
  input wire logic msTick,
  // Raw pin and qualified result
  input wire logic rawIn,
  output logic level,
  output logic rise,
  output logic fall
);
  import fdio_pkg::*;

  localparam int unsigned CW = $clog2(QUAL_TICKS + 1);
  localparam logic [CW-1:0] QUAL_LAST = CW'(QUAL_TICKS);

  typedef struct packed {
    logic [2:0] sync;
    logic lvl;
    logic [CW-1:0] cnt;
    logic rise;
    logic fall;
  } fdio_qual_s;

  fdio_qual_s q, d;

  always_comb
  begin
    d = q;
    d.sync = {q.sync[1:0], rawIn};
    d.rise = 1'b0;
    d.fall = 1'b0;
    // A level counts only once the second and third stages agree.
    if (q.sync[1] != q.sync[2] || q.sync[2] == q.lvl)
    begin
      d.cnt = '0;
    end
    else if (msTick)
    begin
      if (q.cnt == QUAL_LAST - 1'b1)
      begin
        d.cnt = '0;
        d.lvl = q.sync[2];
        d.rise = q.sync[2];
        d.fall = ~q.sync[2];
      end
      else
      begin
        d.cnt = q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0; // [RULE17]
    end
    else
    begin
      q <= d; // [RULE16]
    end
  end

  assign level = q.lvl;
  assign rise = q.rise;
  assign fall = q.fall;

endmodule // fdio_input_qual

// ===== rtl/fdio_discrete_io.sv
// Discrete I/O supervision for a product feeder, with an APB register slave.
// Assumes pins arrive asynchronously and the host machinery reads the status outputs.
//
// Notes on behaviour
// [RULE1] Qualified double detect drives the fault output.
// [RULE2] Trigger during an unfinished cycle flags miss.
// [RULE3] Double and miss indications each enable separately.
// [RULE4] Miss time period settable 20 to 999 ms.
// [RULE5] Busy is high whole time motor runs.
// [RULE6] Done shares busy output after batch completes.
// [RULE7] Ready high whenever a trigger would be accepted.
// [RULE8] Double detect valid only after over 50 ms.
// [RULE9] Low stack change accepted after over 50 ms.
// [RULE10] Low stack repeat follows qualified low stack.
// [RULE11] Run permit low for over 50 ms halts.
// [RULE12] Feeding resumes where halted, not restarted.
// [RULE13] Inverted trigger edge over 50 ms starts cycle.
// [RULE14] Host keeps run permit asserted to feed.
// [RULE15] Halt input enable and operator acknowledge selectable.
// [RULE16] Inputs pass synchronising flops before qualification.
// [RULE17] Millisecond tick times everything; counters reset cleared.
`timescale 1ns/100ps
module fdio_discrete_io #(
  parameter int unsigned TICK_CYCLES = fdio_pkg::TICK_CYCLES,
  parameter int unsigned QUAL_TICKS = fdio_pkg::QUAL_TICKS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register bus
  input wire fdio_pkg::fdio_apb_req_s apbReq,
  output fdio_pkg::fdio_apb_rsp_s apbRsp,
  // Field pins
  input wire fdio_pkg::fdio_pin_in_s pinIn,
  output fdio_pkg::fdio_pin_out_s pinOut,
  // Interrupt
  output logic irq
);
  import fdio_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int unsigned TW = $clog2(TICK_CYCLES);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  typedef struct packed {
    logic [TW-1:0] tickCnt;
    logic msTick;
    logic [3:0] ctrl;
    logic [MS_W-1:0] missMs;
    logic [MS_W-1:0] feedMs;
    logic [15:0] batchSize;
    logic [15:0] batchCnt;
    logic [EV_N-1:0] intStat;
    logic [EV_N-1:0] intMask;
    fdio_feed_e feed;
    logic [MS_W-1:0] feedElapsed;
    logic [MS_W-1:0] sinceTrig;
    logic trigWindow;
    logic [MS_W-1:0] missHold;
    logic missFlag;
    logic doneFlag;
    fdio_apb_rsp_s rsp;
    fdio_pin_out_s pins;
    logic irq;
  } fdio_top_s;

  fdio_top_s q, d;

  // ----------------------------------------------------------------
  // Input qualification
  // ----------------------------------------------------------------
  logic [IN_N-1:0] rawPins;
  logic [IN_N-1:0] qLevel;
  logic [IN_N-1:0] qRise;
  logic [IN_N-1:0] qFall;

  // The trigger pin is active low, so it is inverted here before qualification.
  assign rawPins[IN_DOUBLE] = pinIn.doubleDet; // [RULE8]
  assign rawPins[IN_LOW_STACK] = pinIn.lowStack;
  assign rawPins[IN_RUN_PERMIT] = pinIn.runPermit;
  assign rawPins[IN_TRIGGER] = ~pinIn.triggerN; // [RULE13]

  genvar gi;
  generate
    for (gi = 0; gi < IN_N; gi++)
    begin : gQual
      fdio_input_qual #(
        .QUAL_TICKS(QUAL_TICKS)
      ) uQual (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .msTick(q.msTick),
        .rawIn(rawPins[gi]),
        .level(qLevel[gi]),
        .rise(qRise[gi]),
        .fall(qFall[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [MS_W-1:0] clampMiss(input logic [31:0] v);
    logic [MS_W-1:0] r;
    r = MISS_MS_MIN;
    if (v > 32'(MISS_MS_MAX))
    begin
      r = MISS_MS_MAX;
    end
    else if (v >= 32'(MISS_MS_MIN))
    begin
      r = v[MS_W-1:0];
    end
    return r;
  endfunction

  function automatic logic isMapped(input logic [7:0] a);
    return a inside {ADDR_CTRL, ADDR_MISS_MS, ADDR_FEED_MS, ADDR_BATCH, ADDR_STATUS,
                     ADDR_INT_STAT, ADDR_INT_MASK, ADDR_CMD};
  endfunction

  logic apbAccess;
  logic apbCommit;
  logic wrCommit;
  logic haltActive;
  logic resumeCmd;
  logic clrDoneCmd;
  logic trigEdge;
  logic cycleEnd;
  logic [EV_N-1:0] events;
  logic [31:0] rdData;

  assign apbAccess = apbReq.psel & apbReq.penable;
  assign apbCommit = apbAccess & q.rsp.pready;
  assign wrCommit = apbCommit & apbReq.pwrite & isMapped(apbReq.paddr);
  assign resumeCmd = wrCommit & (apbReq.paddr == ADDR_CMD) & apbReq.pwdata[CMD_RESUME];
  assign clrDoneCmd = wrCommit & (apbReq.paddr == ADDR_CMD) & apbReq.pwdata[CMD_CLR_DONE];
  // Halting only applies when the input is enabled; a disabled input reads as permit.
  assign haltActive = q.ctrl[CTRL_HALT_EN] & ~qLevel[IN_RUN_PERMIT]; // [RULE11] [RULE15]
  assign trigEdge = qRise[IN_TRIGGER]; // [RULE13]
  assign cycleEnd = (q.feed == FEED_RUN) & q.msTick & (q.feedElapsed + 1'b1 >= q.feedMs);

  always_comb
  begin
    rdData = 32'h0000_0000;
    case (apbReq.paddr)
      ADDR_CTRL: rdData[3:0] = q.ctrl;
      ADDR_MISS_MS: rdData[MS_W-1:0] = q.missMs;
      ADDR_FEED_MS: rdData[MS_W-1:0] = q.feedMs;
      ADDR_BATCH: rdData[15:0] = q.batchSize;
      ADDR_STATUS: rdData = {q.batchCnt, 6'h00, q.doneFlag, q.missFlag,
                             2'(q.feed), q.pins.ready, q.pins.motorRun, qLevel};
      ADDR_INT_STAT: rdData[EV_N-1:0] = q.intStat;
      ADDR_INT_MASK: rdData[EV_N-1:0] = q.intMask;
      default: rdData = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    events = '0;

    // Millisecond time base.
    d.msTick = 1'b0;
    if (q.tickCnt == TICK_LAST) // [RULE17]
    begin
      d.tickCnt = '0;
      d.msTick = 1'b1;
    end
    else
    begin
      d.tickCnt = q.tickCnt + 1'b1;
    end

    // Register bus: one wait state, write and read data at the pready edge.
    d.rsp.pready = 1'b0;
    if (apbAccess && !q.rsp.pready)
    begin
      d.rsp.pready = 1'b1;
      d.rsp.prdata = rdData;
      d.rsp.pslverr = ~isMapped(apbReq.paddr);
    end
    else if (!apbAccess)
    begin
      d.rsp.pslverr = 1'b0;
    end
    if (wrCommit)
    begin
      case (apbReq.paddr)
        ADDR_CTRL: d.ctrl = apbReq.pwdata[3:0]; // [RULE3] [RULE15]
        ADDR_MISS_MS: d.missMs = clampMiss(apbReq.pwdata); // [RULE4]
        ADDR_FEED_MS: d.feedMs = apbReq.pwdata[MS_W-1:0];
        ADDR_BATCH: d.batchSize = apbReq.pwdata[15:0];
        ADDR_INT_MASK: d.intMask = apbReq.pwdata[EV_N-1:0];
        default: d.ctrl = d.ctrl;
      endcase
    end

    // Time since the last accepted trigger, saturating at the miss period.
    if (q.trigWindow && q.msTick)
    begin
      if (q.sinceTrig + 1'b1 >= q.missMs)
      begin
        d.trigWindow = 1'b0;
      end
      d.sinceTrig = q.sinceTrig + 1'b1;
    end

    // A clear that meets a batch completion loses, so no finished batch goes unseen.
    if (clrDoneCmd)
    begin
      d.doneFlag = 1'b0;
    end

    // Feed sequencer.
    case (q.feed)
      FEED_IDLE:
      begin
        if (trigEdge && !haltActive)
        begin
          d.feed = FEED_RUN;
          d.feedElapsed = '0;
          d.doneFlag = 1'b0;
          d.trigWindow = 1'b1;
          d.sinceTrig = '0;
        end
      end
      FEED_RUN:
      begin
        if (haltActive)
        begin
          d.feed = FEED_HALT; // [RULE11]
          events[EV_HALT] = 1'b1;
        end
        else if (cycleEnd)
        begin
          d.feed = FEED_IDLE;
          d.feedElapsed = '0;
          if (q.batchSize != 16'h0000 && q.batchCnt + 1'b1 >= q.batchSize)
          begin
            d.batchCnt = '0;
            d.doneFlag = 1'b1; // [RULE6]
            events[EV_DONE] = 1'b1;
          end
          else if (q.batchSize != 16'h0000)
          begin
            d.batchCnt = q.batchCnt + 1'b1;
          end
        end
        else if (q.msTick)
        begin
          d.feedElapsed = q.feedElapsed + 1'b1;
        end
      end
      FEED_HALT:
      begin
        // The elapsed time is frozen, so the cycle picks up where it stopped.
        if (!haltActive)
        begin
          d.feed = q.ctrl[CTRL_ACK_REQ] ? FEED_WAIT_ACK : FEED_RUN; // [RULE12] [RULE15]
        end
      end
      FEED_WAIT_ACK:
      begin
        if (haltActive)
        begin
          d.feed = FEED_HALT;
        end
        else if (resumeCmd)
        begin
          d.feed = FEED_RUN; // [RULE12]
        end
      end
      default:
      begin
        d.feed = FEED_IDLE;
      end
    endcase

    // Miss: a new trigger while the cycle is unfinished or inside the miss period.
    if (trigEdge && q.ctrl[CTRL_MISS_EN] && (q.feed != FEED_IDLE || q.trigWindow)) // [RULE2]
    begin
      d.missFlag = 1'b1;
      d.missHold = '0;
      events[EV_MISS] = 1'b1;
    end
    else if (q.missFlag && q.msTick)
    begin
      // The miss indication is stretched for the configured period.
      if (q.missHold + 1'b1 >= q.missMs) // [RULE4]
      begin
        d.missFlag = 1'b0;
      end
      d.missHold = q.missHold + 1'b1;
    end
    if (!q.ctrl[CTRL_MISS_EN])
    begin
      d.missFlag = 1'b0; // [RULE3]
    end
    events[EV_DOUBLE] = qRise[IN_DOUBLE] & q.ctrl[CTRL_DOUBLE_EN];
    events[EV_LOW_STACK] = qRise[IN_LOW_STACK];

    // Sticky status: a new event wins over a write-one clear in the same cycle.
    if (wrCommit && apbReq.paddr == ADDR_INT_STAT)
    begin
      d.intStat = q.intStat & ~apbReq.pwdata[EV_N-1:0];
    end
    d.intStat = d.intStat | events;
    d.irq = |(d.intStat & d.intMask);

    // Field outputs.
    d.pins.doubleMiss = (qLevel[IN_DOUBLE] & q.ctrl[CTRL_DOUBLE_EN]) | d.missFlag; // [RULE1]
    d.pins.motorRun = (d.feed == FEED_RUN);
    d.pins.busyDone = (d.feed == FEED_RUN) | d.doneFlag; // [RULE5] [RULE6]
    d.pins.ready = (d.feed == FEED_IDLE) & ~haltActive; // [RULE7] [RULE14]
    d.pins.lowStackRpt = qLevel[IN_LOW_STACK]; // [RULE9] [RULE10]
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0; // [RULE17]
      q.ctrl <= CTRL_RESET;
      q.missMs <= MISS_MS_RESET;
      q.feedMs <= FEED_MS_RESET;
      q.batchSize <= BATCH_RESET;
      q.feed <= FEED_IDLE;
    end
    else
    begin
      q <= d;
    end
  end

  assign apbRsp = q.rsp;
  assign pinOut = q.pins;
  assign irq = q.irq;

endmodule // fdio_discrete_io

// ===== dv/fdio_discrete_io_props.sv
// Checker for the feeder discrete I/O block, bound to its top module.
// Sees only the top module ports; counters time how long raw pins stay put.
`timescale 1ns/100ps
module fdio_discrete_io_props #(
  parameter int unsigned TICK_CYCLES = 10,
  parameter int unsigned QUAL_TICKS = 3
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Watched ports
  input wire fdio_pkg::fdio_apb_req_s apbReq,
  input wire fdio_pkg::fdio_apb_rsp_s apbRsp,
  input wire fdio_pkg::fdio_pin_in_s pinIn,
  input wire fdio_pkg::fdio_pin_out_s pinOut,
  input wire logic irq
);
  import fdio_pkg::*;
  // ----
  // Stable time counters
  // ----
  // Shorter than QMIN cycles can never qualify; QMAX always has, sync and tick phase included.
  localparam int QMIN = (QUAL_TICKS - 1) * TICK_CYCLES;
  localparam int QMAX = (QUAL_TICKS + 1) * TICK_CYCLES + 8;
  logic [15:0] lsHi_q, pmHi_q, pmLo_q, tgLo_q;
  function automatic logic [15:0] sat(logic [15:0] c, logic on);
    return on ? c + 16'(c != 16'hffff) : 16'h0000;
  endfunction
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lsHi_q <= '0;
      pmHi_q <= '0;
      pmLo_q <= '0;
      tgLo_q <= '0;
    end
    else
    begin
      lsHi_q <= sat(lsHi_q, pinIn.lowStack);
      pmHi_q <= sat(pmHi_q, pinIn.runPermit);
      pmLo_q <= sat(pmLo_q, !pinIn.runPermit);
      tgLo_q <= sat(tgLo_q, !pinIn.triggerN);
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_pready_pulse: assert property ( // CONTRACT
    apbRsp.pready |=> !apbRsp.pready) else $error("pready held too long");
  a_pready_time: assert property ( // CONTRACT
    apbReq.psel && $rose(apbReq.penable) |=> apbRsp.pready) else $error("pready late");
  a_stack_rise: assert property (
    $rose(pinOut.lowStackRpt) |-> lsHi_q >= QMIN) else $error("low stack taken early");
  a_stack_held: assert property (
    lsHi_q == QMAX |-> pinOut.lowStackRpt) else $error("low stack repeat missing");
  a_motor_busy: assert property (
    pinOut.motorRun |-> pinOut.busyDone) else $error("busy low while motor runs");
  a_ready_idle: assert property (
    pinOut.ready |-> !pinOut.motorRun) else $error("ready while running");
  a_halt_stop: assert property (
    pmLo_q >= QMAX |-> !pinOut.motorRun && !pinOut.ready) else $error("no halt");
  a_start_cause: assert property (
    $rose(pinOut.motorRun) |-> tgLo_q >= QMIN || pmHi_q >= QMIN)
    else $error("motor start without cause");
  c_motor: cover property ($rose(pinOut.motorRun));
  c_fault: cover property ($rose(pinOut.doubleMiss));
  c_irq: cover property ($rose(irq));
endmodule // fdio_discrete_io_props

bind fdio_discrete_io fdio_discrete_io_props #(.TICK_CYCLES(TICK_CYCLES), .QUAL_TICKS(QUAL_TICKS))
  props_u (.core_clk(core_clk), .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp),
  .pinIn(pinIn), .pinOut(pinOut), .irq(irq));

// ===== dv/fdio_host_model.sv
// Host machinery model: relay contacts driving the feeder inputs.
// Assumes the bench commands levels and trigger closures on core_clk.
`timescale 1ns/100ps
module fdio_host_model (
  // Clock
  input wire logic core_clk,
  // Bench commands
  input wire logic permitOn,
  input wire logic doubleOn,
  input wire logic stackLow,
  input wire logic trigGo,
  input wire logic [15:0] trigLen,
  // Contacts seen by the block
  output fdio_pkg::fdio_pin_in_s pinIn
);
  logic [15:0] trigCnt_q = '0;
  always_ff @(posedge core_clk)
  begin
    if (trigGo)
      trigCnt_q <= trigLen;
    else if (trigCnt_q != '0)
      trigCnt_q <= trigCnt_q - 16'h0001;
  end
  // The contact closes for trigLen cycles; the block under test inverts it.
  assign pinIn.triggerN = (trigCnt_q == '0);
  // The permit contact stays closed for as long as the host lets it run.
  assign pinIn.runPermit = permitOn;
  assign pinIn.doubleDet = doubleOn;
  assign pinIn.lowStack = stackLow;
endmodule // fdio_host_model

// ===== dv/fdio_discrete_io_tb.sv
// Self-checking bench for the feeder discrete I/O block.
// Shortened tick: 10 cycles a millisecond, 3 ticks to qualify.
`timescale 1ns/100ps
module fdio_discrete_io_tb;
  import fdio_pkg::*;
  localparam int TICK = 10;
  localparam int FEED = 30;
  localparam int LIM = 20000;
  localparam int O_MOT = 0;
  localparam int O_RPT = 1;
  localparam int O_FLT = 4;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  fdio_apb_req_s apbReq = '0;
  fdio_apb_rsp_s apbRsp;
  fdio_pin_in_s pinIn;
  fdio_pin_out_s pinOut;
  logic irq;
  logic permitOn = 1'b0, doubleOn = 1'b0, stackLow = 1'b0, trigGo = 1'b0;
  logic [15:0] trigLen = '0;
  logic [31:0] rd;
  logic er;
  int errors = 0, checks = 0, cyc = 0, n1, n2;
  fdio_host_model host_u (.core_clk(core_clk), .permitOn(permitOn), .doubleOn(doubleOn),
    .stackLow(stackLow), .trigGo(trigGo), .trigLen(trigLen), .pinIn(pinIn));
  fdio_discrete_io #(.TICK_CYCLES(TICK), .QUAL_TICKS(3)) dut_u (.core_clk(core_clk),
    .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp), .pinIn(pinIn), .pinOut(pinOut), .irq(irq));
  initial
  begin
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == LIM)
    begin
      errors++;
      final_report();
    end
  end
  task final_report;
    if (errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task hold(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge core_clk);
    apbReq.penable <= 1'b1;
    do @(posedge core_clk); while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata;
    er = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask
  task chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    apb(1'b0, a, '0);
    cmp(rd, exp, msg);
  endtask
  task waitv(input int i, input logic v, input int n, input string msg);
    int k;
    k = 0;
    while (pinOut[i] !== v && k < n)
    begin
      @(posedge core_clk);
      k++;
    end
    cmp(pinOut[i], v, msg);
  endtask
  task run_len(output int n);
    n = 0;
    while (pinOut.motorRun === 1'b1 && n < 1000)
    begin
      @(posedge core_clk);
      n++;
    end
  endtask
  task trig(input int ms);
    @(posedge core_clk);
    trigGo <= 1'b1;
    trigLen <= 16'(ms * TICK);
    @(posedge core_clk);
    trigGo <= 1'b0;
  endtask
  task t_reset;
    cmp(32'(pinOut), '0, "outputs after reset");
    chk(ADDR_CTRL, 32'(CTRL_RESET), "ctrl reset");
    chk(ADDR_MISS_MS, 32'(MISS_MS_RESET), "miss reset");
    chk(ADDR_FEED_MS, 32'(FEED_MS_RESET), "feed reset");
    chk(ADDR_BATCH, 32'(BATCH_RESET), "batch reset");
    chk(ADDR_INT_MASK, '0, "mask reset");
    apb(1'b0, 8'h20, '0);
    cmp(er, 1'b1, "unmapped");
    apb(1'b1, ADDR_MISS_MS, 32'd5);
    chk(ADDR_MISS_MS, 32'(MISS_MS_MIN), "miss low clamp");
    apb(1'b1, ADDR_MISS_MS, 32'd1000);
    chk(ADDR_MISS_MS, 32'(MISS_MS_MAX), "miss high clamp");
    apb(1'b1, ADDR_MISS_MS, 32'd20);
    apb(1'b1, ADDR_FEED_MS, FEED);
    permitOn <= 1'b1;
    waitv(2, 1'b1, 80, "ready on permit");
  endtask
  task t_feed;
    trig(1);
    hold(60);
    cmp(pinOut.motorRun, 1'b0, "short trigger");
    trig(8);
    waitv(O_MOT, 1'b1, 60, "feed start");
    cmp(pinOut.busyDone, 1'b1, "busy");
    cmp(pinOut.ready, 1'b0, "ready while busy");
    waitv(O_MOT, 1'b0, FEED * TICK + 20, "feed end");
    hold(3);
    cmp(pinOut.busyDone, 1'b0, "busy off");
    cmp(pinOut.ready, 1'b1, "ready again");
  endtask
  task t_double;
    doubleOn <= 1'b1;
    hold(10);
    doubleOn <= 1'b0;
    hold(60);
    cmp(pinOut.doubleMiss, 1'b0, "short double");
    doubleOn <= 1'b1;
    waitv(O_FLT, 1'b1, 60, "double fault");
    apb(1'b0, ADDR_INT_STAT, '0);
    cmp(rd[EV_DOUBLE], 1'b1, "double event");
    hold(1);
    doubleOn <= 1'b0;
    waitv(O_FLT, 1'b0, 60, "double off");
    apb(1'b1, ADDR_CTRL, 32'h6);
    doubleOn <= 1'b1;
    hold(80);
    cmp(pinOut.doubleMiss, 1'b0, "double disabled");
    doubleOn <= 1'b0;
    hold(60);
    apb(1'b1, ADDR_CTRL, 32'h7);
  endtask
  task t_stack;
    stackLow <= 1'b1;
    hold(10);
    stackLow <= 1'b0;
    hold(60);
    cmp(pinOut.lowStackRpt, 1'b0, "short low stack");
    stackLow <= 1'b1;
    waitv(O_RPT, 1'b1, 60, "low stack on");
    apb(1'b0, ADDR_INT_STAT, '0);
    cmp(rd[EV_LOW_STACK], 1'b1, "low stack event");
    hold(1);
    stackLow <= 1'b0;
    hold(10);
    stackLow <= 1'b1;
    hold(60);
    cmp(pinOut.lowStackRpt, 1'b1, "short release");
    stackLow <= 1'b0;
    waitv(O_RPT, 1'b0, 60, "low stack off");
  endtask
  task miss_pair;
    trig(5);
    waitv(O_MOT, 1'b1, 60, "first start");
    hold(50);
    trig(5);
  endtask
  task t_miss;
    apb(1'b1, ADDR_INT_STAT, 32'h1f);
    miss_pair();
    waitv(O_FLT, 1'b1, 80, "miss");
    apb(1'b0, ADDR_INT_STAT, '0);
    cmp(rd[EV_MISS], 1'b1, "miss event");
    cmp(irq, 1'b0, "masked irq");
    apb(1'b1, ADDR_INT_MASK, 32'h2);
    hold(2);
    cmp(irq, 1'b1, "irq raised");
    apb(1'b1, ADDR_INT_STAT, 32'h2);
    hold(2);
    cmp(irq, 1'b0, "irq cleared");
    waitv(O_MOT, 1'b0, 400, "miss run end");
    waitv(O_FLT, 1'b0, 300, "miss expires");
    apb(1'b1, ADDR_CTRL, 32'h5);
    miss_pair();
    hold(100);
    cmp(pinOut.doubleMiss, 1'b0, "miss disabled");
    waitv(O_MOT, 1'b0, 400, "run end");
    apb(1'b1, ADDR_CTRL, 32'h7);
  endtask
  task t_halt;
    trig(5);
    waitv(O_MOT, 1'b1, 60, "halt start");
    hold(50);
    permitOn <= 1'b0;
    run_len(n1);
    cmp(pinOut.ready, 1'b0, "halted");
    apb(1'b0, ADDR_INT_STAT, '0);
    cmp(rd[EV_HALT], 1'b1, "halt event");
    hold(40);
    permitOn <= 1'b1;
    waitv(O_MOT, 1'b1, 80, "resume");
    run_len(n2);
    n1 = 50 + n1 + n2;
    cmp(n1 inside {[FEED * TICK - 20 : FEED * TICK + 20]}, 1'b1, "resume length");
    apb(1'b1, ADDR_CTRL, 32'hf);
    trig(5);
    waitv(O_MOT, 1'b1, 60, "ack start");
    permitOn <= 1'b0;
    waitv(O_MOT, 1'b0, 80, "ack halt");
    hold(40);
    permitOn <= 1'b1;
    hold(80);
    cmp(pinOut.motorRun, 1'b0, "waits for resume");
    apb(1'b1, ADDR_CMD, 32'h1);
    waitv(O_MOT, 1'b1, 20, "resume command");
    waitv(O_MOT, 1'b0, 400, "ack end");
    apb(1'b1, ADDR_CTRL, 32'h7);
  endtask
  task t_batch;
    apb(1'b1, ADDR_BATCH, 32'd2);
    repeat (2)
    begin
      hold(210);
      trig(5);
      waitv(O_MOT, 1'b1, 60, "batch start");
      waitv(O_MOT, 1'b0, 400, "batch end");
    end
    hold(3);
    cmp(pinOut.busyDone, 1'b1, "done");
    apb(1'b0, ADDR_INT_STAT, '0);
    cmp(rd[EV_DONE], 1'b1, "done event");
    chk(ADDR_STATUS, 32'h0000_0224, "status done");
    apb(1'b1, ADDR_CMD, 32'h2);
    hold(3);
    cmp(pinOut.busyDone, 1'b0, "done cleared");
  endtask
  initial
  begin
    hold(2);
    rst_n <= 1'b1;
    hold(2);
    t_reset();
    t_feed();
    t_double();
    t_stack();
    t_miss();
    t_halt();
    t_batch();
    final_report();
  end
endmodule // fdio_discrete_io_tb
